// >>> core/ovv_pkg.sv
// Constants, register map and types of the overvoltage protection block.
//
// Behaviour
// - Emergency status bit 0 reads 1 while emergency-stop protection is active.
// - Emergency status bit 1 returns the emergency-stop input level; no reset value.
// - Selected input low for the filter length forces all six phase outputs in modes 01, 10 and 11.
// - Engaging overvoltage protection raises an overvoltage interrupt request.
// - Software selects forcing of upper phases, lower phases or all phases.
// - Protection-state status bit reads 1 while overvoltage protection is active.
// - With auto-release set, protection ends itself after the input is deasserted.
// - Protection holds while the input is low; input level is readable.
// - Automatic release happens only when the PWM counter equals the period or, with half-cycle interrupt, one.
// - With half-cycle interrupt configured, release also when the counter equals one.
// - Clearing the enable bit is accepted only directly after the key sequence.
// - Detection-time field in bits 11 to 8; zero is treated as one.
// - Filter length is the detection-time value times 16 clock periods.
// - Filter applies only to the port pin source; monitor signal passes unfiltered.
// - Bit 6 of the control register enables monitor function 1 as input.
// - Mode 00 no control, 01 upper active, 10 lower active, 11 all inactive.
// - Source select 0 picks the port pin, 1 the enabled monitor outputs.
// - Simultaneous emergency stop and overvoltage use the emergency-stop output mode.
package ovv_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_ESTOP_STATUS = 32'h0000_0000;
   localparam logic [31:0] ADDR_OVV_CONTROL = 32'h0000_0004;
   localparam logic [31:0] ADDR_OVV_STATUS = 32'h0000_0008;
   localparam logic [31:0] ADDR_RELEASE_KEY = 32'h0000_000c;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTL_ENABLE = 0;
   localparam int CTL_AUTO_RELEASE = 1;
   localparam int CTL_SOURCE_SEL = 2;
   localparam int CTL_MODE_LO = 3;
   localparam int CTL_MODE_HI = 4;
   localparam int CTL_MON0_EN = 5;
   localparam int CTL_MON1_EN = 6;
   localparam int CTL_COUNT_LO = 8;
   localparam int CTL_COUNT_HI = 11;
   localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_0f7f;

   // ------------------------------------------------------------
   // Status fields, key codes and response codes
   // ------------------------------------------------------------
   localparam int STA_STATE = 0;
   localparam int STA_LEVEL = 1;
   localparam logic [7:0] KEY_FIRST = 8'h5a;
   localparam logic [7:0] KEY_SECOND = 8'ha5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Filter timing
   // ------------------------------------------------------------
   localparam int FILTER_UNIT = 16;
   localparam int FILTER_WIDTH = 8;
   localparam logic [3:0] COUNT_MIN = 4'h1;
   localparam logic [3:0] COUNT_ZERO = 4'h0;
   localparam logic [15:0] HALF_POINT = 16'h0001;

   // ------------------------------------------------------------
   // Modes and states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_UPPER = 2'h1,
      MODE_LOWER = 2'h2,
      MODE_ALL_OFF = 2'h3
   } mode_e;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'h0,
      KEY_HALF = 2'h1,
      KEY_ARMED = 2'h3
   } key_e;

   typedef enum logic [2:0] {
      SEL_ESTOP = 3'h0,
      SEL_CONTROL = 3'h1,
      SEL_STATUS = 3'h2,
      SEL_KEY = 3'h3,
      SEL_NONE = 3'h4
   } sel_e;

endpackage : ovv_pkg

// >>> core/filter_if.sv
// Interface between the protection core and its input noise filter.
`timescale 1ns/1ps
interface filter_if;
   logic raw_level;
   logic [3:0] length;
   logic bypass;
   logic level;

   modport core (output raw_level, output length, output bypass, input level);
   modport filter (input raw_level, input length, input bypass, output level);
endinterface : filter_if

// >>> core/ovv_filter.sv
// Noise filter for the active-low overvoltage input.
`timescale 1ns/1ps
module ovv_filter
   import ovv_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Filter connection
   filter_if.filter link
);

   logic [FILTER_WIDTH-1:0] low_count;
   logic [FILTER_WIDTH-1:0] next_low_count;
   logic level;
   logic next_level;
   logic [FILTER_WIDTH-1:0] limit;
   logic [3:0] eff_length;

   // A low level must persist for the whole length before it is passed on.
   always_comb begin
      eff_length = (link.length == COUNT_ZERO) ? COUNT_MIN : link.length;
      limit = FILTER_WIDTH'(eff_length * FILTER_UNIT);
      next_low_count = low_count;
      next_level = level;
      if (link.bypass) begin
         next_low_count = '0;
         next_level = link.raw_level;
      end else if (link.raw_level) begin
         next_low_count = '0;
         next_level = 1'b1;
      end else if (low_count >= limit - FILTER_WIDTH'(1)) begin
         next_level = 1'b0;
      end else begin
         next_low_count = low_count + FILTER_WIDTH'(1);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         low_count <= '0;
         level <= 1'b1;
      end else begin
         low_count <= next_low_count;
         level <= next_level;
      end
   end

   assign link.level = level;

endmodule : ovv_filter

// >>> core/ovv_protect.sv
// Overvoltage protection control with emergency status and AXI4-Lite registers.
`timescale 1ns/1ps
module ovv_protect
   import ovv_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // AXI4-Lite write address and data
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // AXI4-Lite write response
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // AXI4-Lite read
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [31:0] ARADDR,
   input wire logic [2:0] ARPROT,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // Overvoltage sources
   input wire logic OVV_PIN_N,
   input wire logic MONITOR0_HIT,
   input wire logic MONITOR1_HIT,
   // Emergency-stop logic
   input wire logic ESTOP_IN_N,
   input wire logic ESTOP_ACTIVE,
   input wire logic [1:0] ESTOP_MODE,
   // PWM timing reference
   input wire logic [15:0] PWM_COUNT,
   input wire logic [15:0] PWM_PERIOD,
   input wire logic HALF_CYCLE_IRQ_EN,
   // Phase outputs, upper phases in bits 2:0, lower in bits 5:3
   input wire logic [5:0] PWM_IN,
   input wire logic POL_UPPER,
   input wire logic POL_LOWER,
   output logic [5:0] PHASE_OUT,
   output logic [5:0] PHASE_OE,
   // Protection status
   output logic OVV_IRQ,
   output logic PROTECT_STATE
);

   // ------------------------------------------------------------
   // Address decoding
   // ------------------------------------------------------------
   function automatic sel_e decode(input logic [31:0] addr);
      if (addr == ADDR_ESTOP_STATUS) begin
         return SEL_ESTOP;
      end else if (addr == ADDR_OVV_CONTROL) begin
         return SEL_CONTROL;
      end else if (addr == ADDR_OVV_STATUS) begin
         return SEL_STATUS;
      end else if (addr == ADDR_RELEASE_KEY) begin
         return SEL_KEY;
      end else begin
         return SEL_NONE;
      end
   endfunction : decode

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic aw_held, next_aw_held;
   logic [31:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic [31:0] control, next_control;
   key_e key_state, next_key_state;
   logic protect, next_protect;
   logic prev_level, next_prev_level;
   logic irq, next_irq;
   logic [5:0] phase_out, next_phase_out;
   logic [5:0] phase_oe, next_phase_oe;

   logic do_write;
   sel_e wsel;
   logic sel_level;
   logic monitor_level;
   logic boundary;
   logic engage;
   logic [31:0] estop_word;
   logic [31:0] status_word;
   mode_e ovv_mode;
   mode_e estop_mode;

   filter_if filt ();

   ovv_filter ovv_filter_inst (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .link(filt.filter)
   );

   // ------------------------------------------------------------
   // Input selection and status words
   // ------------------------------------------------------------
   always_comb begin
      monitor_level = !((MONITOR0_HIT && control[CTL_MON0_EN]) ||
                        (MONITOR1_HIT && control[CTL_MON1_EN]));
      sel_level = control[CTL_SOURCE_SEL] ? monitor_level : OVV_PIN_N;
      estop_word = '0;
      estop_word[STA_STATE] = ESTOP_ACTIVE;
      estop_word[STA_LEVEL] = ESTOP_IN_N;
      status_word = '0;
      status_word[STA_STATE] = protect;
      status_word[STA_LEVEL] = sel_level;
   end

   assign filt.raw_level = sel_level;
   assign filt.length = control[CTL_COUNT_HI:CTL_COUNT_LO];
   assign filt.bypass = control[CTL_SOURCE_SEL];

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   assign AWREADY = !aw_held && !bvalid;
   assign WREADY = !w_held && !bvalid;
   assign ARREADY = !rvalid;
   assign do_write = aw_held && w_held && !bvalid;
   assign wsel = decode(aw_addr);

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (AWVALID && AWREADY) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && WREADY) begin
         next_w_held = 1'b1;
         next_w_data = WDATA;
         next_w_strb = WSTRB;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && BREADY) begin
         next_bvalid = 1'b0;
      end
      if (ARVALID && ARREADY) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case (decode(ARADDR))
            SEL_ESTOP: next_rdata = estop_word;
            SEL_CONTROL: next_rdata = control & CTL_WRITE_MASK;
            SEL_STATUS: next_rdata = status_word;
            SEL_KEY: next_rdata = '0;
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end else if (rvalid && RREADY) begin
         next_rvalid = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Control register and disable key
   // ------------------------------------------------------------
   always_comb begin
      next_control = control;
      next_key_state = key_state;
      if (do_write) begin
         next_key_state = KEY_IDLE;
         if (wsel == SEL_KEY && w_strb[0]) begin
            if (key_state == KEY_IDLE && w_data[7:0] == KEY_FIRST) begin
               next_key_state = KEY_HALF;
            end else if (key_state == KEY_HALF && w_data[7:0] == KEY_SECOND) begin
               next_key_state = KEY_ARMED;
            end
         end else if (wsel == SEL_CONTROL) begin
            if (w_strb[0]) begin
               next_control[7:0] = w_data[7:0] & CTL_WRITE_MASK[7:0];
               if (control[CTL_ENABLE] && key_state != KEY_ARMED) begin
                  next_control[CTL_ENABLE] = 1'b1;
               end
            end
            if (w_strb[1]) begin
               next_control[15:8] = w_data[15:8] & CTL_WRITE_MASK[15:8];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Protection state
   // ------------------------------------------------------------
   always_comb begin
      boundary = (PWM_COUNT == PWM_PERIOD) ||
                 (HALF_CYCLE_IRQ_EN && PWM_COUNT == HALF_POINT);
      engage = control[CTL_ENABLE] && prev_level && !filt.level;
      next_prev_level = filt.level;
      next_protect = protect;
      next_irq = 1'b0;
      if (!control[CTL_ENABLE]) begin
         next_protect = 1'b0;
      end else if (engage && !protect) begin
         next_protect = 1'b1;
         next_irq = 1'b1;
      end else if (protect && control[CTL_AUTO_RELEASE] && filt.level && boundary) begin
         next_protect = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Phase output forcing
   // ------------------------------------------------------------
   always_comb begin
      ovv_mode = mode_e'(control[CTL_MODE_HI:CTL_MODE_LO]);
      estop_mode = mode_e'(ESTOP_MODE);
      next_phase_out = PWM_IN;
      next_phase_oe = '1;
      if (ESTOP_ACTIVE) begin
         case (estop_mode)
            MODE_UPPER: next_phase_oe = 6'h07;
            MODE_LOWER: next_phase_oe = 6'h38;
            default: next_phase_oe = 6'h00;
         endcase
      end else if (protect) begin
         case (ovv_mode)
            MODE_UPPER: next_phase_out = {{3{!POL_LOWER}}, {3{POL_UPPER}}};
            MODE_LOWER: next_phase_out = {{3{POL_LOWER}}, {3{!POL_UPPER}}};
            MODE_ALL_OFF: next_phase_out = {{3{!POL_LOWER}}, {3{!POL_UPPER}}};
            default: next_phase_out = PWM_IN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
         control <= '0;
         key_state <= KEY_IDLE;
         protect <= 1'b0;
         prev_level <= 1'b1;
         irq <= 1'b0;
         phase_out <= '0;
         phase_oe <= '0;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         control <= next_control;
         key_state <= next_key_state;
         protect <= next_protect;
         prev_level <= next_prev_level;
         irq <= next_irq;
         phase_out <= next_phase_out;
         phase_oe <= next_phase_oe;
      end
   end

   assign BVALID = bvalid;
   assign BRESP = bresp;
   assign RVALID = rvalid;
   assign RDATA = rdata;
   assign RRESP = rresp;
   assign PHASE_OUT = phase_out;
   assign PHASE_OE = phase_oe;
   assign OVV_IRQ = irq;
   assign PROTECT_STATE = protect;

endmodule : ovv_protect

// >>> bench/ovv_source_model.sv
// Overvoltage pin source and PWM counter beside the protection block.
`timescale 1ns/1ps
module ovv_source_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Requests from the bench
   input wire logic trip,
   input wire logic [15:0] period,
   // Signals seen by the block
   output logic pin_n,
   output logic [15:0] count
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_n <= 1'h1;
         count <= 16'h0;
      end else begin
         pin_n <= !trip;
         count <= (count >= period) ? 16'h0 : count + 16'h1;
      end
   end
endmodule : ovv_source_model

// >>> bench/ovv_protect_assertions.sv
// Concurrent checks of the overvoltage protection block at its ports.
`timescale 1ns/1ps
module ovv_protect_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   // Timing and outputs
   input wire logic ESTOP_ACTIVE,
   input wire logic [1:0] ESTOP_MODE,
   input wire logic [15:0] PWM_COUNT,
   input wire logic [15:0] PWM_PERIOD,
   input wire logic HALF_CYCLE_IRQ_EN,
   input wire logic [5:0] PWM_IN,
   input wire logic [5:0] PHASE_OUT,
   input wire logic [5:0] PHASE_OE,
   input wire logic OVV_IRQ,
   input wire logic PROTECT_STATE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   AST_IRQ_ON_ENGAGE: assert property (
      OVV_IRQ |-> PROTECT_STATE && !$past(PROTECT_STATE))
      else $error("Interrupt without a new protection state.");
   AST_ENGAGE_IRQ: assert property ($rose(PROTECT_STATE) |-> OVV_IRQ)
      else $error("Protection began without an interrupt.");
   AST_IRQ_PULSE: assert property (OVV_IRQ |=> !OVV_IRQ)
      else $error("Interrupt longer than one cycle.");
   AST_RELEASE_POINT: assert property (
      $fell(PROTECT_STATE) |-> $past(PWM_COUNT == PWM_PERIOD ||
      (HALF_CYCLE_IRQ_EN && PWM_COUNT == 16'h1)) || $past(BVALID) || $past(BVALID, 2))
      else $error("Release off the PWM boundary.");
   AST_OE_NORMAL: assert property (
      $past(RESET_N) && !$past(ESTOP_ACTIVE) |-> PHASE_OE == 6'h3f)
      else $error("Drive enables off without emergency stop.");
   AST_OE_ESTOP: assert property (
      $past(ESTOP_ACTIVE) |-> PHASE_OE ==
      {{3{$past(ESTOP_MODE) == 2'h2}}, {3{$past(ESTOP_MODE) == 2'h1}}})
      else $error("Drive enables differ from emergency mode.");
   AST_PASS_NORMAL: assert property (
      $past(RESET_N) && !PROTECT_STATE && !$past(PROTECT_STATE) && !$past(ESTOP_ACTIVE)
      |-> PHASE_OUT == $past(PWM_IN))
      else $error("Phase outputs do not follow PWM levels.");
   AST_READ_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("Read not answered after one cycle.");
   AST_WRITE_ANSWER: assert property (
      AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
      else $error("Write not answered after two cycles.");

   cover property ($rose(PROTECT_STATE));
   cover property ($fell(PROTECT_STATE) && HALF_CYCLE_IRQ_EN);
   cover property (ESTOP_ACTIVE && PROTECT_STATE);
endmodule : ovv_protect_assertions

bind ovv_protect ovv_protect_assertions ovv_protect_assertions_inst (.CLK, .RESET_N,
   .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .ARVALID, .ARREADY, .RVALID,
   .ESTOP_ACTIVE, .ESTOP_MODE, .PWM_COUNT, .PWM_PERIOD, .HALF_CYCLE_IRQ_EN, .PWM_IN,
   .PHASE_OUT, .PHASE_OE, .OVV_IRQ, .PROTECT_STATE);

// >>> bench/tb_ovv_protect.sv
// Self-checking testbench of the overvoltage protection block.
`timescale 1ns/1ps
module tb_ovv_protect
   import ovv_pkg::*;
;
   logic CLK = 1'h0, RESET_N = 1'h0, trip = 1'h0;
   logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h1, ARVALID = 1'h0, RREADY = 1'h1;
   logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OVV_IRQ, PROTECT_STATE, OVV_PIN_N;
   logic [1:0] BRESP, RRESP, ESTOP_MODE = 2'h0;
   logic MONITOR0_HIT = 1'h0, MONITOR1_HIT = 1'h0, ESTOP_IN_N = 1'h1, ESTOP_ACTIVE = 1'h0;
   logic HALF_CYCLE_IRQ_EN = 1'h0;
   logic [15:0] PWM_COUNT, PWM_PERIOD = 16'h28;
   logic [5:0] PWM_IN = 6'h2a, PHASE_OUT, PHASE_OE;
   logic [3:0] cnts [3] = '{4'h0, 4'h1, 4'h3};
   logic [5:0] outs [4] = '{6'h2a, 6'h07, 6'h38, 6'h00};
   int mismatches = 0, samples_checked = 0, n, len;
   logic s, q;

   ovv_protect ovv_protect_inst (.CLK, .RESET_N, .AWVALID, .AWREADY, .AWADDR,
      .AWPROT(3'h0), .WVALID, .WREADY, .WDATA, .WSTRB(4'hf), .BVALID, .BREADY, .BRESP,
      .ARVALID, .ARREADY, .ARADDR, .ARPROT(3'h0), .RVALID, .RREADY, .RDATA, .RRESP,
      .OVV_PIN_N, .MONITOR0_HIT, .MONITOR1_HIT, .ESTOP_IN_N, .ESTOP_ACTIVE, .ESTOP_MODE,
      .PWM_COUNT, .PWM_PERIOD, .HALF_CYCLE_IRQ_EN, .PWM_IN, .POL_UPPER(1'h1),
      .POL_LOWER(1'h1), .PHASE_OUT, .PHASE_OE, .OVV_IRQ, .PROTECT_STATE);
   ovv_source_model ovv_source_model_inst (.clk(CLK), .reset_n(RESET_N), .trip(trip),
      .period(PWM_PERIOD), .pin_n(OVV_PIN_N), .count(PWM_COUNT));

   // ------
   // Bus and check tasks
   // ------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ka, kw, kb;
      int i;
      kb = 1'h0;
      i = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      while (!kb && i < 100) begin
         @(negedge CLK);
         ka = AWVALID && AWREADY;
         kw = WVALID && WREADY;
         kb = BVALID;
         if (kb) chk(BRESP, r);
         @(posedge CLK);
         i++;
         if (ka) AWVALID <= 1'h0;
         if (kw) WVALID <= 1'h0;
      end
      chk(kb, 1'h1);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ka, kr;
      int i;
      kr = 1'h0;
      i = 0;
      ARADDR <= a;
      ARVALID <= 1'h1;
      while (!kr && i < 100) begin
         @(negedge CLK);
         ka = ARVALID && ARREADY;
         kr = RVALID;
         if (kr) chk({RDATA[31:2], RRESP}, {e[31:2], r});
         if (kr) chk(RDATA[1:0], e[1:0]);
         @(posedge CLK);
         i++;
         if (ka) ARVALID <= 1'h0;
      end
      chk(kr, 1'h1);
   endtask : rd

   task automatic key(input logic [7:0] a, input logic [7:0] b);
      wr(ADDR_RELEASE_KEY, {24'h0, a}, RESP_OKAY);
      wr(ADDR_RELEASE_KEY, {24'h0, b}, RESP_OKAY);
   endtask : key

   task automatic off();
      key(KEY_FIRST, KEY_SECOND);
      wr(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
   endtask : off

   task automatic wait_state(input logic e, input int lim);
      n = 0;
      do begin
         @(negedge CLK);
         s = PROTECT_STATE;
         q = OVV_IRQ;
         @(posedge CLK);
         n++;
      end while (s !== e && n < lim);
   endtask : wait_state

   task automatic finish_test();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // ------
   // Clock, watchdog and tests
   // ------
   initial begin
      forever #12.5 CLK = !CLK;
   end

   initial begin
      repeat (20000) @(posedge CLK);
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (5) @(posedge CLK);
      RESET_N <= 1'h1;
      @(posedge CLK);
      rd(ADDR_ESTOP_STATUS, 32'h2, RESP_OKAY);
      rd(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_OVV_STATUS, 32'h2, RESP_OKAY);
      rd(ADDR_RELEASE_KEY, 32'h0, RESP_OKAY);
      rd(32'h10, 32'h0, RESP_SLVERR);
      wr(32'h10, 32'hffffffff, RESP_SLVERR);
      wr(ADDR_OVV_CONTROL, 32'hffffffff, RESP_OKAY);
      rd(ADDR_OVV_CONTROL, CTL_WRITE_MASK, RESP_OKAY);
      wr(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_OVV_CONTROL, 32'h1, RESP_OKAY);
      key(KEY_SECOND, KEY_FIRST);
      wr(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_OVV_CONTROL, 32'h1, RESP_OKAY);
      key(KEY_FIRST, KEY_SECOND);
      wr(ADDR_RELEASE_KEY, 32'h0, RESP_OKAY);
      wr(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_OVV_CONTROL, 32'h1, RESP_OKAY);
      off();
      rd(ADDR_OVV_CONTROL, 32'h0, RESP_OKAY);
      foreach (cnts[i]) begin
         off();
         trip <= 1'h0;
         len = (cnts[i] == 4'h0 ? 1 : int'(cnts[i])) * FILTER_UNIT;
         wr(ADDR_OVV_CONTROL, {20'h0, cnts[i], 8'h09}, RESP_OKAY);
         trip <= 1'h1;
         repeat (len - 4) @(posedge CLK);
         trip <= 1'h0;
         wait_state(1'h1, len + 8);
         chk(s, 1'h0);
         trip <= 1'h1;
         wait_state(1'h1, len + 10);
         chk(n >= len && n <= len + 6, 1'h1);
         chk(q, 1'h1);
         rd(ADDR_OVV_STATUS, 32'h1, RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_OVV_CONTROL, {20'h0, 4'h3, 3'h0, 2'(i), 3'h1}, RESP_OKAY);
         @(negedge CLK);
         chk(PHASE_OUT, outs[i]);
         @(posedge CLK);
      end
      ESTOP_ACTIVE <= 1'h1;
      ESTOP_MODE <= 2'h1;
      ESTOP_IN_N <= 1'h0;
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      chk(PHASE_OE, 6'h07);
      @(posedge CLK);
      rd(ADDR_ESTOP_STATUS, 32'h1, RESP_OKAY);
      ESTOP_ACTIVE <= 1'h0;
      ESTOP_IN_N <= 1'h1;
      wr(ADDR_OVV_CONTROL, 32'h30b, RESP_OKAY);
      wait_state(1'h0, 90);
      chk(s, 1'h1);
      wr(ADDR_OVV_CONTROL, 32'h309, RESP_OKAY);
      trip <= 1'h0;
      wait_state(1'h0, 90);
      chk(s, 1'h1);
      wr(ADDR_OVV_CONTROL, 32'h30b, RESP_OKAY);
      wait_state(1'h0, 50);
      chk(s, 1'h0);
      HALF_CYCLE_IRQ_EN <= 1'h1;
      trip <= 1'h1;
      wait_state(1'h1, 60);
      chk(s, 1'h1);
      // Drop the input just before the wrap so that only the count-one point can release.
      do @(negedge CLK); while (PWM_COUNT != 16'h26);
      @(posedge CLK);
      trip <= 1'h0;
      wait_state(1'h0, 8);
      chk(s, 1'h0);
      off();
      HALF_CYCLE_IRQ_EN <= 1'h0;
      wr(ADDR_OVV_CONTROL, 32'hf05, RESP_OKAY);
      MONITOR0_HIT <= 1'h1;
      wait_state(1'h1, 20);
      chk(s, 1'h0);
      wr(ADDR_OVV_CONTROL, 32'hf45, RESP_OKAY);
      MONITOR1_HIT <= 1'h1;
      wait_state(1'h1, 8);
      chk(s, 1'h1);
      chk(q, 1'h1);
      rd(ADDR_OVV_STATUS, 32'h1, RESP_OKAY);
      off();
      wait_state(1'h0, 4);
      chk(s, 1'h0);
      finish_test();
   end
endmodule : tb_ovv_protect
